/* src/tvp_top.sv */
// Timed valve positioner top level
`timescale 1ns/100ps
module tvp_top
    import tvp_pkg::*;
#(
    parameter int TICK_CYC = TVP_TICK_CYC,
    parameter int WORD_W = TVP_WORD_W
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [1:0] ADDR,
    input wire logic [WORD_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [WORD_W-1:0] RDATA,
    input wire logic ENABLE,
    output logic VALVE_OPEN,
    output logic VALVE_CLOSE
);
    logic rst_n;
    logic tick;
    logic en_q;
    logic signed [WORD_W-1:0] target_q;
    logic [WORD_W-1:0] pos_q;
    logic [WORD_W-1:0] travel_q;
    tvp_motion_t motion_q;
    tvp_motion_t motion_d;
    logic [WORD_W-1:0] param_w;
    logic signed [WORD_W:0] tgt_x;
    logic signed [WORD_W:0] pos_x;
    logic signed [WORD_W:0] trv_x;

    tvp_rst_sync u_rst (
        .clk(CLK),
        .arst_n(RESETN),
        .rst_n(rst_n)
    );

    tvp_tick #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .clk(CLK),
        .rst_n(rst_n),
        .run(ENABLE),
        .tick(tick)
    );

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else begin
            en_q <= ENABLE;
        end
    end

    // Only the target and travel words are writable; position and parameter words ignore writes
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            target_q <= TVP_TARGET_RST;
            travel_q <= TVP_TRAVEL_RST;
        end else if (WR) begin
            if (ADDR == TVP_ADDR_TARGET) begin
                target_q <= WDATA;
            end
            if (ADDR == TVP_ADDR_TRAVEL) begin
                travel_q <= WDATA;
            end
        end
    end

    // Signed compare in tenth-second units
    assign tgt_x = {target_q[WORD_W-1], target_q};
    assign pos_x = {1'b0, pos_q};
    assign trv_x = {1'b0, travel_q};

    // Direction decided from target versus tracked position
    always_comb begin
        motion_d = TVP_IDLE;
        if (!ENABLE) begin
            motion_d = TVP_IDLE;
        end else if (tgt_x > trv_x) begin
            motion_d = TVP_OPENING;
        end else if (tgt_x < 0) begin
            motion_d = TVP_CLOSING;
        end else if (tgt_x > pos_x) begin
            motion_d = TVP_OPENING;
        end else if (tgt_x < pos_x) begin
            motion_d = TVP_CLOSING;
        end else begin
            motion_d = TVP_IDLE;
        end
    end

    // Motion state changes on the 10 Hz tick or in the first cycle after enable, and drops at once when disabled
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            motion_q <= TVP_IDLE;
        end else if (!ENABLE) begin
            motion_q <= TVP_IDLE;
        end else if (!en_q || tick) begin
            motion_q <= motion_d;
        end
    end

    // Position starts at zero on enable and holds while disabled
    // Held outputs past travel or below zero keep driving, position clamps
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= '0;
        end else if (ENABLE && !en_q) begin
            pos_q <= '0;
        end else if (ENABLE && tick) begin
            // Step only while the drive is really on; the decision lags a tick and would overshoot
            if (VALVE_OPEN && pos_q < travel_q) begin
                pos_q <= pos_q + 1'b1;
            end else if (VALVE_CLOSE && pos_q != '0) begin
                pos_q <= pos_q - 1'b1;
            end
        end
    end

    // Internal parameter word reports enable and motion
    always_comb begin
        param_w = '0;
        param_w[TVP_PARAM_EN_BIT] = en_q;
        param_w[TVP_PARAM_OPEN_BIT] = motion_q == TVP_OPENING;
        param_w[TVP_PARAM_CLOSE_BIT] = motion_q == TVP_CLOSING;
    end

    // Three consecutive words of the target block, then the travel time
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= '0;
        end else if (RD) begin
            unique case (ADDR)
                TVP_ADDR_TARGET: RDATA <= target_q;
                TVP_ADDR_POS: RDATA <= pos_q;
                TVP_ADDR_PARAM: RDATA <= param_w;
                TVP_ADDR_TRAVEL: RDATA <= travel_q;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    // One-hot decode of a single state keeps both outputs from ever being high
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            VALVE_OPEN <= 1'b0;
            VALVE_CLOSE <= 1'b0;
        end else begin
            VALVE_OPEN <= ENABLE && motion_d == TVP_OPENING && (motion_q == TVP_OPENING);
            VALVE_CLOSE <= ENABLE && motion_d == TVP_CLOSING && (motion_q == TVP_CLOSING);
        end
    end
endmodule

/* src/tvp_pkg.sv */
// Package with constants for the timed valve positioner
package tvp_pkg;
    localparam int TVP_CLK_HZ = 250000000;
    localparam int TVP_TICK_MS = 100;
    localparam int TVP_TICK_CYC = TVP_CLK_HZ / 1000 * TVP_TICK_MS;
    localparam int TVP_WORD_W = 16;
    localparam logic [1:0] TVP_ADDR_TARGET = 2'h0;
    localparam logic [1:0] TVP_ADDR_POS = 2'h1;
    localparam logic [1:0] TVP_ADDR_PARAM = 2'h2;
    localparam logic [1:0] TVP_ADDR_TRAVEL = 2'h3;
    localparam logic [15:0] TVP_TARGET_RST = 16'h0000;
    localparam logic [15:0] TVP_TRAVEL_RST = 16'h0064;
    localparam int TVP_PARAM_EN_BIT = 0;
    localparam int TVP_PARAM_OPEN_BIT = 1;
    localparam int TVP_PARAM_CLOSE_BIT = 2;
    typedef enum logic [1:0] {
        TVP_IDLE = 2'b00,
        TVP_OPENING = 2'b01,
        TVP_CLOSING = 2'b10
    } tvp_motion_t;
endpackage

/* src/tvp_tick.sv */
// Tick generator for 0.1 s time units
`timescale 1ns/100ps
module tvp_tick
    import tvp_pkg::*;
#(
    parameter int TICK_CYC = TVP_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic tick
);
    logic [31:0] cnt_q;

    // Restarts on enable so the first unit is a full tenth of a second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0;
        end else if (!run || cnt_q == 32'(TICK_CYC - 1)) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= run && cnt_q == 32'(TICK_CYC - 1);
        end
    end
endmodule

/* src/tvp_rst_sync.sv */
// Reset release synchroniser
`timescale 1ns/100ps
module tvp_rst_sync (
    input wire logic clk,
    input wire logic arst_n,
    output logic rst_n
);
    logic meta_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            rst_n <= meta_q;
        end
    end
endmodule

/* dv/tvp_top_properties.sv */
// Port checker for the timed valve positioner
`timescale 1ns/100ps
module tvp_top_chk #(
    parameter int TICK_CYC = 10
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [1:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire logic ENABLE,
    input wire logic VALVE_OPEN,
    input wire logic VALVE_CLOSE
);
    // Decisions wait for the next tick, plus a little pipeline slack
    localparam int WIN = TICK_CYC + 4;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    both_excl_a: assert property (!(VALVE_OPEN && VALVE_CLOSE)) else $error("both drives");
    off_idle_a: assert property (!ENABLE |=> !VALVE_OPEN && !VALVE_CLOSE) else $error("drive off");
    rd_idle_a: assert property (!RD |=> RDATA == 16'h0000) else $error("read idle");
    tgt_echo_a: assert property (WR && ADDR == 2'h0 ##2 RD && ADDR == 2'h0 |=> RDATA == $past(WDATA, 3))
        else $error("target echo");
    open_hold_a: assert property ($rose(VALVE_OPEN) |-> (VALVE_OPEN || !ENABLE) [*8]) else $error("open");
    close_hold_a: assert property ($rose(VALVE_CLOSE) |-> (VALVE_CLOSE || !ENABLE) [*8]) else $error("close");
    neg_close_a: assert property (ENABLE && WR && ADDR == 2'h0 && WDATA[15] |-> ##[1:WIN] VALVE_CLOSE)
        else $error("neg");
    over_open_a: assert property (ENABLE && WR && ADDR == 2'h0 && !WDATA[15] && WDATA > 16'h0064
        |-> ##[1:WIN] VALVE_OPEN) else $error("over");
endmodule
bind tvp_top tvp_top_chk #(.TICK_CYC(TICK_CYC)) u_chk (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .ENABLE(ENABLE), .VALVE_OPEN(VALVE_OPEN), .VALVE_CLOSE(VALVE_CLOSE));

/* dv/tvp_valve_model.sv */
// Actuator model that integrates drive time into valve travel
`timescale 1ns/100ps
module tvp_valve_model (
    input wire logic clk,
    input wire logic drv_open,
    input wire logic drv_close,
    output int pos_cyc
);
    initial pos_cyc = 0;
    // Travel in clock cycles; a shut valve cannot close further
    always @(posedge clk) begin
        if (drv_open && !drv_close) begin
            pos_cyc <= pos_cyc + 1;
        end else if (drv_close && !drv_open && pos_cyc > 0) begin
            pos_cyc <= pos_cyc - 1;
        end
    end
endmodule

/* dv/tvp_top_tb.sv */
// Self-checking bench for the timed valve positioner
`timescale 1ns/100ps
module tvp_top_tb;
    import tvp_pkg::*;
    localparam int TC = 10;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [1:0] ADDR = 2'h0;
    logic [15:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic ENABLE = 1'b0;
    logic [15:0] RDATA;
    logic VALVE_OPEN;
    logic VALVE_CLOSE;
    int pos_cyc;
    int n_errors = 0;
    int n_checks = 0;
    always #2 CLK = ~CLK;
    tvp_top #(.TICK_CYC(TC)) u_dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .ENABLE(ENABLE), .VALVE_OPEN(VALVE_OPEN), .VALVE_CLOSE(VALVE_CLOSE));
    tvp_valve_model u_valve (.clk(CLK), .drv_open(VALVE_OPEN), .drv_close(VALVE_CLOSE), .pos_cyc(pos_cyc));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] v); // Only the target word is written, well inside a tick
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= TVP_ADDR_TARGET;
        WDATA <= v;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [15:0] exp);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(RDATA, exp);
    endtask
    task automatic drv(input logic [1:0] exp);
        #1 chk({14'h0000, VALVE_OPEN, VALVE_CLOSE}, {14'h0000, exp});
    endtask
    task automatic move(input logic [15:0] t);
        int i;
        i = 0;
        wr(t);
        repeat (TC + 3) @(posedge CLK);
        while ((VALVE_OPEN || VALVE_CLOSE) && i < 2000) begin
            @(posedge CLK);
            i++;
        end
        drv(2'b00);
        rd(TVP_ADDR_POS, t);
        chk(16'((pos_cyc + 5) / TC), t);
    endtask
    task automatic t_start();
        rd(TVP_ADDR_TRAVEL, TVP_TRAVEL_RST);
        rd(TVP_ADDR_TARGET, TVP_TARGET_RST);
        ENABLE <= 1'b1;
        wr(16'hffff);
        rd(TVP_ADDR_TARGET, 16'hffff);
        repeat (1100) @(posedge CLK);
        drv(2'b01);
        rd(TVP_ADDR_POS, 16'h0000);
        rd(TVP_ADDR_PARAM, 16'h0005);
        $display("start done");
    endtask
    task automatic t_steps();
        move(16'h0028);
        move(16'h0014);
        move(16'h001e);
        move(16'h000a);
        $display("steps done");
    endtask
    task automatic t_over();
        wr(16'h0096);
        repeat (1100) @(posedge CLK);
        drv(2'b10);
        rd(TVP_ADDR_POS, 16'h0064);
        $display("over done");
    endtask
    task automatic t_off();
        @(posedge CLK);
        ENABLE <= 1'b0;
        repeat (3) @(posedge CLK);
        drv(2'b00);
        rd(TVP_ADDR_POS, 16'h0064);
        wr(16'h0002);
        ENABLE <= 1'b1;
        rd(TVP_ADDR_POS, 16'h0000);
        repeat (4 * TC) @(posedge CLK);
        rd(TVP_ADDR_POS, 16'h0002);
        $display("off done");
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (3) @(posedge CLK);
        t_start();
        t_steps();
        t_over();
        t_off();
        results();
    end
    // About six times the expected length of the run
    initial begin
        repeat (20000) @(posedge CLK);
        n_errors++;
        results();
    end
endmodule
